/* File: swclk_ctrl.sv */
// How it works
// - Mode comes from the resistor pin: populated is internal, floating is external.
// - Resistor setting picks the oscillator period, clamped to 100 kHz..2 MHz switching.
// - Without a resistor the internal oscillator never runs or switches.
// - Internal mode drives the shared clock pin with the double-rate clock.
// - The driven shared clock is in phase with the primary drive outputs.
// - Floating resistor pin selects external mode; shared clock pin becomes input.
// - External mode switches at half the received clock frequency.
// - External clock is inverted; cycles start on its falling edges.
// - External mode keeps primary drives low until the clock is present.
// - A secondary inverts the clock, giving 90 or 270 degree offset.
// - Soft start done flags once the ramp passes the reference comparator.
// - Rectifier drives stay low until the ramp passes the 1 V comparator.
// - Switching needs supply, reference, enable, fault clear and thermal all good.
`timescale 1ns/1ps
`default_nettype none
module swclk_ctrl
	import swclk_pkg::*;
(
	// Clock, reset and enable.
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	// Configuration pins.
	input wire logic FREQ_SET_RESISTOR_PIN,
	input wire logic [HALF_W-1:0] FREQ_HALF_PERIOD,
	// Shared clock pin.
	input wire logic SYNC_I,
	output logic SYNC_O,
	output logic SYNC_OE,
	// Soft-start comparators and start qualifiers.
	input wire logic SS_ABOVE_REF,
	input wire logic SS_ABOVE_1V,
	input wire logic SUPPLY_OK,
	input wire logic REF_OK,
	input wire logic ENABLE,
	input wire logic FAULT_CLEAR,
	input wire logic THERMAL_OK,
	// Drives and status.
	output logic PRIMARY_DRIVE_A,
	output logic PRIMARY_DRIVE_B,
	output logic RECTIFIER_DRIVE_A,
	output logic RECTIFIER_DRIVE_B,
	output logic SS_DONE,
	output logic CLOCK_PRESENT
);
	pin_sync_if pins ();
	logic [IN_W-1:0] s;
	osc_mode_t mode_q;
	logic run_q;
	logic [HALF_W-1:0] half_lim;
	logic [HALF_W-1:0] osc_cnt_q;
	logic osc_q;
	logic osc_prev_q;
	logic sync_prev_q;
	logic [TMR_W-1:0] tmr_q;
	logic present_q;
	logic tick;
	logic dbl_lvl;
	logic phase_q;
	logic phase_d;
	logic active;

	// Every input except CLK, RESET and CE passes two flops before any logic reads it.
	assign pins.raw = {FREQ_HALF_PERIOD, THERMAL_OK, FAULT_CLEAR, ENABLE, REF_OK, SUPPLY_OK,
		SS_ABOVE_1V, SS_ABOVE_REF, SYNC_I, FREQ_SET_RESISTOR_PIN};
	assign s = pins.synced;

	pin_sync #(.STAGES(SYNC_STAGES)) u_sync (
		.clk(CLK),
		.reset(RESET),
		.ce(CE),
		.p(pins.syn)
	);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			mode_q <= MODE_EXT;
			run_q <= 1'b0;
		end else if (CE) begin
			mode_q <= s[B_RES] ? MODE_INT : MODE_EXT;
			run_q <= s[B_UVLO] & s[B_REFOK] & s[B_EN] & s[B_FLTCLR] & s[B_THERM];
		end
	end

	// A bad resistor setting is clamped rather than letting the rate leave its range.
	always_comb begin
		half_lim = s[B_HALF +: HALF_W];
		if (half_lim < HALF_MIN) begin
			half_lim = HALF_MIN;
		end else if (half_lim > HALF_MAX) begin
			half_lim = HALF_MAX;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			osc_cnt_q <= '0;
			osc_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end else if (CE) begin
			osc_prev_q <= osc_q;
			if (mode_q != MODE_INT || !run_q) begin
				osc_cnt_q <= '0;
				osc_q <= 1'b0;
			end else if (osc_cnt_q >= half_lim - 8'h01) begin
				osc_cnt_q <= '0;
				osc_q <= ~osc_q;
			end else begin
				osc_cnt_q <= osc_cnt_q + 8'h01;
			end
		end
	end

	// Whichever edge a secondary first sees sets the 90 or 270 degree offset.
	always_comb begin
		if (mode_q == MODE_INT) begin
			tick = osc_q & ~osc_prev_q;
			dbl_lvl = osc_q;
		end else begin
			tick = sync_prev_q & ~s[B_SYNC];
			dbl_lvl = ~s[B_SYNC];
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			sync_prev_q <= 1'b0;
			tmr_q <= TMR_LIMIT;
			present_q <= 1'b0;
		end else if (CE) begin
			sync_prev_q <= s[B_SYNC];
			// Presence restarts after a mode change; internal clock edges still in the synchroniser can still set it.
			if (mode_q == MODE_INT) begin
				tmr_q <= TMR_LIMIT;
				present_q <= 1'b0;
			end else if (sync_prev_q != s[B_SYNC]) begin
				tmr_q <= '0;
				present_q <= 1'b1;
			end else if (tmr_q < TMR_LIMIT) begin
				tmr_q <= tmr_q + 11'h001;
			end else begin
				present_q <= 1'b0;
			end
		end
	end

	assign active = run_q & (mode_q == MODE_INT || present_q);
	assign phase_d = tick ? ~phase_q : phase_q;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			phase_q <= 1'b1;
		end else if (CE) begin
			phase_q <= active ? phase_d : 1'b1;
		end
	end

	// Drives and the clock out share one register stage so they stay aligned.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			PRIMARY_DRIVE_A <= 1'b0;
			PRIMARY_DRIVE_B <= 1'b0;
			RECTIFIER_DRIVE_A <= 1'b0;
			RECTIFIER_DRIVE_B <= 1'b0;
			SYNC_O <= 1'b0;
			SYNC_OE <= 1'b0;
			SS_DONE <= 1'b0;
			CLOCK_PRESENT <= 1'b0;
		end else if (CE) begin
			PRIMARY_DRIVE_A <= active & ~phase_d & dbl_lvl;
			PRIMARY_DRIVE_B <= active & phase_d & dbl_lvl;
			RECTIFIER_DRIVE_A <= active & s[B_SS1V] & ~phase_d & ~dbl_lvl;
			RECTIFIER_DRIVE_B <= active & s[B_SS1V] & phase_d & ~dbl_lvl;
			SYNC_O <= osc_q & (mode_q == MODE_INT);
			SYNC_OE <= (mode_q == MODE_INT);
			SS_DONE <= run_q & s[B_SSREF];
			CLOCK_PRESENT <= present_q | (mode_q == MODE_INT);
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	property p_oe_int;
		CE && mode_q == MODE_INT |=> SYNC_OE;
	endproperty
	a_oe_int: assert property (p_oe_int) else $error("Clock pin not driven in internal mode");

	property p_oe_ext;
		CE && mode_q == MODE_EXT |=> !SYNC_OE && !SYNC_O;
	endproperty
	a_oe_ext: assert property (p_oe_ext) else $error("Clock pin driven in external mode");

	property p_no_clock;
		CE && mode_q == MODE_EXT && !present_q |=> !PRIMARY_DRIVE_A && !PRIMARY_DRIVE_B;
	endproperty
	a_no_clock: assert property (p_no_clock) else $error("Drive active without clock");

	property p_sr_gate;
		CE && !s[B_SS1V] |=> !RECTIFIER_DRIVE_A && !RECTIFIER_DRIVE_B;
	endproperty
	a_sr_gate: assert property (p_sr_gate) else $error("Rectifier active below 1 V");

	property p_start;
		CE && !run_q |=> !PRIMARY_DRIVE_A && !PRIMARY_DRIVE_B && !SS_DONE;
	endproperty
	a_start: assert property (p_start) else $error("Switching before qualifiers");

	property p_alt;
		CE && tick && active |=> phase_q != $past(phase_q);
	endproperty
	a_alt: assert property (p_alt) else $error("Phase did not alternate");

	property p_inv;
		CE && run_q && present_q && mode_q == MODE_EXT && sync_prev_q && !s[B_SYNC] |=>
			PRIMARY_DRIVE_A || PRIMARY_DRIVE_B;
	endproperty
	a_inv: assert property (p_inv) else $error("Falling edge did not start a cycle");

	property p_ss;
		CE |=> SS_DONE == $past(run_q && s[B_SSREF]);
	endproperty
	a_ss: assert property (p_ss) else $error("Soft start flag wrong");

	property p_range;
		half_lim >= HALF_MIN && osc_cnt_q < HALF_MAX;
	endproperty
	a_range: assert property (p_range) else $error("Oscillator period out of range");

	property p_inphase;
		CE && mode_q == MODE_INT && run_q && !$past(osc_q) && osc_q && !phase_q |=>
			SYNC_O && PRIMARY_DRIVE_B;
	endproperty
	a_inphase: assert property (p_inphase) else $error("Clock out not in phase");

	c_int_a: cover property (SYNC_OE && PRIMARY_DRIVE_A);
	c_ext_b: cover property (!SYNC_OE && PRIMARY_DRIVE_B);
	c_sr_on: cover property (RECTIFIER_DRIVE_A && SS_DONE);
	c_lost: cover property ($fell(CLOCK_PRESENT));
endmodule : swclk_ctrl
`default_nettype wire

/* File: swclk_pkg.sv */
package swclk_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// Double-rate clock bounds: 4 MHz gives the shortest half period, 200 kHz the longest.
	localparam int DBL_HALF_MIN_NS = 125;
	localparam int DBL_HALF_MAX_NS = 2500;
	localparam int DBL_HALF_MIN_CYC = (DBL_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DBL_HALF_MAX_CYC = DBL_HALF_MAX_NS / CLK_PERIOD_NS;
	localparam int HALF_W = 8;
	localparam logic [HALF_W-1:0] HALF_MIN = HALF_W'(DBL_HALF_MIN_CYC);
	localparam logic [HALF_W-1:0] HALF_MAX = HALF_W'(DBL_HALF_MAX_CYC);
	// An applied clock counts as present while edges come closer than this.
	localparam int SYNC_TIMEOUT_NS = 10000;
	localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int TMR_W = 11;
	localparam logic [TMR_W-1:0] TMR_LIMIT = TMR_W'(SYNC_TIMEOUT_CYC);
	localparam int SYNC_STAGES = 2;
	// Synchronised input vector: bit positions.
	localparam int IN_W = 9 + HALF_W;
	localparam int B_RES = 0;
	localparam int B_SYNC = 1;
	localparam int B_SSREF = 2;
	localparam int B_SS1V = 3;
	localparam int B_UVLO = 4;
	localparam int B_REFOK = 5;
	localparam int B_EN = 6;
	localparam int B_FLTCLR = 7;
	localparam int B_THERM = 8;
	localparam int B_HALF = 9;
	typedef enum logic {MODE_EXT, MODE_INT} osc_mode_t;
endpackage : swclk_pkg

/* File: pin_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
	import swclk_pkg::*;
	logic [IN_W-1:0] raw;
	logic [IN_W-1:0] synced;
	modport src (output raw, input synced);
	modport syn (input raw, output synced);
endinterface : pin_sync_if
`default_nettype wire

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import swclk_pkg::*;
#(
	parameter int STAGES = SYNC_STAGES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	pin_sync_if.syn p
);
	logic [IN_W-1:0] stage_q [STAGES];

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_q[i] <= '0;
			end
		end else if (ce) begin
			stage_q[0] <= p.raw;
			for (int i = 1; i < STAGES; i++) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	assign p.synced = stage_q[STAGES-1];
endmodule : pin_sync
`default_nettype wire

/* File: ext_clk_src.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_clk_src #(
	parameter int HIGH_NS = 125,
	parameter int LOW_NS = 125
) (
	// Control and clock out.
	input wire logic run,
	output logic clk_o
);
	// An even split keeps the high time centred, well inside the allowed band.
	// The start is offset by 1 ns so no link edge lands on a system clock edge.
	initial begin
		clk_o = 1'b0;
		forever begin
			@(posedge run);
			#1;
			while (run) begin
				clk_o = 1'b1;
				#HIGH_NS;
				clk_o = 1'b0;
				#LOW_NS;
			end
		end
	end
endmodule : ext_clk_src
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import swclk_pkg::*;
	logic clk = 0, rst = 1, res_pin = 0, ce = 1, run = 0, sr = 0, s1 = 0;
	logic [4:0] q = 5'h1f;
	logic [HALF_W-1:0] half = 8'h14;
	logic ext, so, soe, pa, pb, ra, rb, done, pres, lp, la, lb;
	wire logic pin = soe ? so : ext;
	int n_mismatch = 0, n_tests = 0, rl, ll, ups, na, nb;
	always #5 clk = ~clk;
	ext_clk_src i_ext_clk_src (.run(run), .clk_o(ext));
	swclk_ctrl i_swclk_ctrl (.CLK(clk), .RESET(rst), .CE(ce),
		.FREQ_SET_RESISTOR_PIN(res_pin),
		.FREQ_HALF_PERIOD(half), .SYNC_I(pin), .SYNC_O(so), .SYNC_OE(soe), .SS_ABOVE_REF(sr),
		.SS_ABOVE_1V(s1), .SUPPLY_OK(q[0]), .REF_OK(q[1]), .ENABLE(q[2]), .FAULT_CLEAR(q[3]),
		.THERMAL_OK(q[4]), .PRIMARY_DRIVE_A(pa), .PRIMARY_DRIVE_B(pb), .RECTIFIER_DRIVE_A(ra),
		.RECTIFIER_DRIVE_B(rb), .SS_DONE(done), .CLOCK_PRESENT(pres));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk
	// Samples only settled stretches, so synchroniser latency never counts against the design.
	task automatic watch(input int n, input logic act);
		int bad;
		bad = 0; rl = 0; ll = 0; ups = 0; na = 0; nb = 0;
		lp = pin; la = pa; lb = pb;
		repeat (n) begin
			@(negedge clk);
			if (pin !== lp) begin
				ll = rl;
				rl = 0;
				ups += int'(pin === act);
			end
			rl++;
			na += int'(pa & !la);
			nb += int'(pb & !lb);
			if (rl > 5 && ((pa | pb) !== (pin === act) || (pa & pb) !== 1'b0)) bad++;
			if (!act && rl > 5 && (ra | rb) !== (pin !== act && s1)) bad++;
			lp = pin; la = pa; lb = pb;
		end
		chk("drive shape", 16'h0, 16'(bad));
		chk("phase split", 16'h1, 16'(na - nb <= 1 && nb - na <= 1 && na + nb >= ups - 1));
	endtask : watch
	task automatic t_internal();
		logic [7:0] hv[3] = '{8'h05, 8'h14, 8'hff};
		logic [7:0] ev[3] = '{HALF_MIN, 8'h14, HALF_MAX};
		res_pin = 1;
		foreach (hv[i]) begin
			half = hv[i];
			repeat (20) @(negedge clk);
			watch(6 * ev[i] + 20, 1'b1);
			chk("sync oe", 16'h1, 16'(soe));
			chk("half period", 16'(ev[i]), 16'(ll));
		end
		lp = so;
		ce = 0;
		repeat (300) @(negedge clk);
		chk("frozen clock", 16'(lp), 16'(so));
		ce = 1;
		chk("ss done low", 16'h0, 16'(done));
		sr = 1;
		repeat (6) @(negedge clk);
		chk("ss done", 16'h1, 16'(done));
		$display("test internal done");
	endtask : t_internal
	task automatic t_quals();
		half = 8'h14;
		for (int i = 0; i < 5; i++) begin
			q = ~(5'h01 << i);
			repeat (10) @(negedge clk);
			watch(60, 1'b1);
			chk("stopped", 16'h0, 16'({so, pa, pb, done}));
			chk("no edges", 16'h0, 16'(ups));
		end
		q = 5'h1f;
		$display("test qualifiers done");
	endtask : t_quals
	task automatic t_external();
		res_pin = 0;
		repeat (20) @(negedge clk);
		chk("idle present", 16'h0, 16'(pres));
		chk("idle drives", 16'h0, 16'({pa, pb, ra, rb, soe}));
		run = 1;
		for (int v = 0; v < 2; v++) begin
			s1 = v[0];
			repeat (20) @(negedge clk);
			watch(400, 1'b0);
			chk("sync oe", 16'h0, 16'(soe));
			chk("present", 16'h1, 16'(pres));
			chk("pulses", 16'h1, 16'(na + nb <= ups + 1 && na > 0));
		end
		run = 0;
		repeat (SYNC_TIMEOUT_CYC - 50) @(negedge clk);
		chk("still present", 16'h1, 16'(pres));
		repeat (90) @(negedge clk);
		chk("present", 16'h0, 16'(pres));
		chk("drives", 16'h0, 16'({pa, pb, ra, rb}));
		$display("test external done");
	endtask : t_external
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (12) @(negedge clk);
		chk("reset outs", 16'h0, 16'({so, soe, pa, pb, ra, rb, done, pres}));
		rst = 0;
		t_internal();
		t_quals();
		t_external();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
